// ### design/tcsps_pkg.sv
// Shared constants for the Type-C source power sequencer
package tcsps_pkg;

	// ----------------------------------------------------------------
	// Clock and tick
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int TICK_W = 16;

	// ----------------------------------------------------------------
	// Timing figures in milliseconds
	// ----------------------------------------------------------------
	localparam int MS_W = 13;
	localparam logic [12:0] T_DEBOUNCE_MS = 13'h00B9;   // 185 ms
	localparam logic [12:0] T_FAULT_HR_MS = 13'h0258;   // 600 ms
	localparam logic [12:0] T_NORESP_MS = 13'h12C0;     // 4.8 s
	localparam logic [12:0] T_ATTACH_RAIL_MS = 13'h0005; // 5 ms max
	localparam logic [12:0] T_VCONN_MS = 13'h0002;      // 2 ms max
	localparam logic [12:0] T_VBUS_ON_MS = 13'h0002;    // 2 ms max
	localparam logic [12:0] T_TURN_ON_MS = 13'h0001;    // Inside both
	localparam logic [12:0] T_HR_GATE_MS = 13'h001E;    // 30 ms
	localparam logic [12:0] T_RECOVER_MS = 13'h02FD;    // 765 ms
	localparam logic [12:0] MS_ONE = 13'h0001;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEBOUNCE = 3'b001,
		ST_ATTACHED = 3'b010,
		ST_HARDRST = 3'b011,
		ST_RECOVER = 3'b100
	} tcsps_state_t;

	// Synchronised pin vector layout
	localparam int PIN_W = 8;
	localparam int PIN_CC1 = 0;
	localparam int PIN_CC2 = 1;
	localparam int PIN_VBUSLOW = 2;
	localparam int PIN_OVRN = 3;
	localparam int PIN_SUPPLY = 4;
	localparam int PIN_FOVP = 5;
	localparam int PIN_OCP = 6;
	localparam int PIN_TEMP = 7;

endpackage

// ### design/tcsps_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module tcsps_sync #(
	parameter int WIDTH = tcsps_pkg::PIN_W
) (
	input wire logic mclk,               // System clock
	input wire logic nrst,               // Synchronous reset, low
	input wire logic [WIDTH-1:0] pinIn,  // Raw asynchronous levels
	output logic [WIDTH-1:0] pinSync     // Levels in mclk domain
);

	// ----------------------------------------------------------------
	// One flop pair per bit; first stage feeds only the second
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic stage1_r;
			logic stage1_nxt;
			logic stage2_r;
			logic stage2_nxt;
			always_comb begin
				stage1_nxt = nrst ? pinIn[gi] : 1'b0;
				stage2_nxt = nrst ? stage1_r : 1'b0;
			end
			always_ff @(posedge mclk) begin
				stage1_r <= stage1_nxt;
				stage2_r <= stage2_nxt;
			end
			assign pinSync[gi] = stage2_r;
		end
	endgenerate

endmodule

// ### design/tcsps_tick.sv
// Free-running millisecond tick generator
`timescale 1ns/1ns
module tcsps_tick #(
	parameter int CYC_PER_MS = tcsps_pkg::CYC_PER_MS
) (
	input wire logic mclk,  // System clock
	input wire logic nrst,  // Synchronous reset, low
	output logic msTick     // One-cycle pulse each millisecond
);

	localparam logic [tcsps_pkg::TICK_W-1:0] TICK_LAST =
		tcsps_pkg::TICK_W'(CYC_PER_MS - 1);
	localparam logic [tcsps_pkg::TICK_W-1:0] TICK_ONE = 16'h0001;

	logic [tcsps_pkg::TICK_W-1:0] cnt_r;
	logic [tcsps_pkg::TICK_W-1:0] cnt_nxt;
	logic tick_r;
	logic tick_nxt;

	// ----------------------------------------------------------------
	// Never stops, so every timer shares one time base
	// ----------------------------------------------------------------
	always_comb begin
		cnt_nxt = cnt_r + TICK_ONE;
		tick_nxt = 1'b0;
		if (cnt_r == TICK_LAST) begin
			cnt_nxt = '0;
			tick_nxt = 1'b1;
		end
		if (!nrst) begin
			cnt_nxt = '0;
			tick_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		cnt_r <= cnt_nxt;
		tick_r <= tick_nxt;
	end

	assign msTick = tick_r;

endmodule

// ### design/tcsps_top.sv
// Type-C source attach, power sequencing and retry timing
// Contract
// - Override low or no supply: hard reset 600 ms after indicator low.
// - Silent sink: keep gate on 4.8 s, then hard reset, repeating.
// - Attach rail output goes high within 5 ms of attach.
// - Override low turns the NFET gate off within 5 us.
// - Fast overvoltage turns the NFET gate off within 30 us.
// - Large overcurrent starts NFET gate turn-off within 30 us.
// - Over-temperature stops VBUS discharge within 10 us.
// - VCONN switch enabled at most 2 ms after indicator low.
// - NFET gate fully on at most 2 ms after indicator low.
// - Both CC pins give attach detection and cable orientation.
// - 5 V is the default source voltage before negotiation.
// - VBUS stays unpowered until a sink is attached.
// - Sink removal is detected and acted on.
// - After attach, offer power over CC; sink negotiates there.
// - All PD layers live inside the device; this design leaves them to an external PD engine driven by pdEnable.
// - Attach indicator goes low after 185 ms debounce.
// - NFET gate disabled 30 ms after a hard reset is sent.
`timescale 1ns/1ns
module tcsps_top #(
	parameter int CYC_PER_MS = tcsps_pkg::CYC_PER_MS
) (
	input wire logic mclk,           // 50 MHz clock
	input wire logic nrst,           // Synchronous reset, low
	input wire logic cc1Rd,          // CC1 sees sink pull-down
	input wire logic cc2Rd,          // CC2 sees sink pull-down
	input wire logic vbusLow,        // VBUS below safe threshold
	input wire logic gate_override_n, // External gate override, low
	input wire logic supply_monitor, // Supply present
	input wire logic fastOvp,        // VBUS above fast OVP level
	input wire logic current_sense_in, // Large overcurrent step
	input wire logic die_temp_limit, // Die over thermal limit
	input wire logic pdMsgRx,        // Pulse: good message from sink
	input wire logic pdHighVoltReq,  // Contract above 5 V agreed
	output logic attach_indicator_n, // Sink attached, low
	output logic attach_rail_out,    // Attach indicator rail
	output logic ccOrient,           // High: CC2 carries the CC wire
	output logic vconnEn,            // VCONN switch enable
	output logic vconnToCc2,         // VCONN routed to CC2
	output logic vbus_nfet_gate,     // VBUS NFET gate driver enable
	output logic sel5v,              // Default 5 V source select
	output logic dischargeEn,        // VBUS discharge enable
	output logic pdEnable,           // PD engine active
	output logic hardResetTx         // Pulse: transmit hard reset
);

	// ----------------------------------------------------------------
	// Pin synchronisation and time base
	// ----------------------------------------------------------------
	logic [tcsps_pkg::PIN_W-1:0] pinRaw;
	logic [tcsps_pkg::PIN_W-1:0] pinS;
	logic msTick;

	assign pinRaw = {die_temp_limit, current_sense_in, fastOvp,
		supply_monitor, gate_override_n, vbusLow, cc2Rd, cc1Rd};

	tcsps_sync #(.WIDTH(tcsps_pkg::PIN_W)) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.pinIn(pinRaw),
		.pinSync(pinS)
	);

	tcsps_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
		.mclk(mclk),
		.nrst(nrst),
		.msTick(msTick)
	);

	logic sCc1, sCc2, sVbusLow, sOvrN, sSupply, sFovp, sOcp, sTemp;
	assign sCc1 = pinS[tcsps_pkg::PIN_CC1];
	assign sCc2 = pinS[tcsps_pkg::PIN_CC2];
	assign sVbusLow = pinS[tcsps_pkg::PIN_VBUSLOW];
	assign sOvrN = pinS[tcsps_pkg::PIN_OVRN];
	assign sSupply = pinS[tcsps_pkg::PIN_SUPPLY];
	assign sFovp = pinS[tcsps_pkg::PIN_FOVP];
	assign sOcp = pinS[tcsps_pkg::PIN_OCP];
	assign sTemp = pinS[tcsps_pkg::PIN_TEMP];

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	tcsps_pkg::tcsps_state_t state_r, state_nxt;
	logic [tcsps_pkg::MS_W-1:0] debMs_r, debMs_nxt;
	logic [tcsps_pkg::MS_W-1:0] onMs_r, onMs_nxt;
	logic [tcsps_pkg::MS_W-1:0] silentMs_r, silentMs_nxt;
	logic [tcsps_pkg::MS_W-1:0] hrMs_r, hrMs_nxt;
	logic orient_r, orient_nxt;
	logic fastLatch_r, fastLatch_nxt;
	logic gate_r, gate_nxt;
	logic vconn_r, vconn_nxt;
	logic indN_r, indN_nxt;
	logic rail_r, rail_nxt;
	logic dsc_r, dsc_nxt;
	logic sel5_r, sel5_nxt;
	logic pdEn_r, pdEn_nxt;
	logic hrTx_r, hrTx_nxt;
	logic [1:0] warm_r, warm_nxt;

	logic oneRd;
	logic monRd;
	logic live;
	logic detach;
	logic supplyFault;
	logic powerOk;

	always_comb begin
		oneRd = sCc1 ^ sCc2;
		monRd = orient_r ? sCc2 : sCc1;
		live = (state_r == tcsps_pkg::ST_ATTACHED) ||
			(state_r == tcsps_pkg::ST_HARDRST) ||
			(state_r == tcsps_pkg::ST_RECOVER);
		detach = live && !monRd;
		supplyFault = !sOvrN || !sSupply;
		// Next value, so a recovery restart cannot flash the gate on
		powerOk = !supplyFault && !fastLatch_r &&
			(onMs_nxt >= tcsps_pkg::T_TURN_ON_MS);
	end

	always_comb begin
		state_nxt = state_r;
		debMs_nxt = debMs_r;
		onMs_nxt = onMs_r;
		silentMs_nxt = silentMs_r;
		hrMs_nxt = hrMs_r;
		orient_nxt = orient_r;
		fastLatch_nxt = fastLatch_r;
		indN_nxt = indN_r;
		rail_nxt = rail_r;
		hrTx_nxt = 1'b0;
		case (state_r)
			tcsps_pkg::ST_IDLE: begin
				if (oneRd && sVbusLow) begin
					state_nxt = tcsps_pkg::ST_DEBOUNCE;
					debMs_nxt = '0;
					orient_nxt = sCc2;
				end
			end
			tcsps_pkg::ST_DEBOUNCE: begin
				// Any wobble restarts the whole debounce from idle
				if (!oneRd || !sVbusLow || (sCc2 != orient_r)) begin
					state_nxt = tcsps_pkg::ST_IDLE;
				end else if (msTick) begin
					if (debMs_r == tcsps_pkg::T_DEBOUNCE_MS - tcsps_pkg::MS_ONE) begin
						state_nxt = tcsps_pkg::ST_ATTACHED;
						indN_nxt = 1'b0;
						rail_nxt = 1'b1;
						onMs_nxt = '0;
						silentMs_nxt = '0;
						fastLatch_nxt = 1'b0;
					end else begin
						debMs_nxt = debMs_r + tcsps_pkg::MS_ONE;
					end
				end
			end
			tcsps_pkg::ST_ATTACHED: begin
				if (sFovp || sOcp) begin
					fastLatch_nxt = 1'b1;
				end
				if (pdMsgRx) begin
					silentMs_nxt = '0;
				end else if (msTick) begin
					silentMs_nxt = silentMs_r + tcsps_pkg::MS_ONE;
				end
				if (msTick && onMs_r != tcsps_pkg::T_FAULT_HR_MS) begin
					onMs_nxt = onMs_r + tcsps_pkg::MS_ONE;
				end
				if (msTick && supplyFault &&
					onMs_r == tcsps_pkg::T_FAULT_HR_MS - tcsps_pkg::MS_ONE) begin
					state_nxt = tcsps_pkg::ST_HARDRST;
					hrTx_nxt = 1'b1;
					hrMs_nxt = '0;
				end else if (msTick && !pdMsgRx &&
					silentMs_r == tcsps_pkg::T_NORESP_MS - tcsps_pkg::MS_ONE) begin
					state_nxt = tcsps_pkg::ST_HARDRST;
					hrTx_nxt = 1'b1;
					hrMs_nxt = '0;
				end
			end
			tcsps_pkg::ST_HARDRST: begin
				if (sFovp || sOcp) begin
					fastLatch_nxt = 1'b1;
				end
				if (msTick) begin
					if (hrMs_r == tcsps_pkg::T_HR_GATE_MS - tcsps_pkg::MS_ONE) begin
						state_nxt = tcsps_pkg::ST_RECOVER;
						hrMs_nxt = '0;
					end else begin
						hrMs_nxt = hrMs_r + tcsps_pkg::MS_ONE;
					end
				end
			end
			tcsps_pkg::ST_RECOVER: begin
				// VBUS held off, then a fresh turn-on attempt
				if (msTick) begin
					if (hrMs_r == tcsps_pkg::T_RECOVER_MS - tcsps_pkg::MS_ONE) begin
						state_nxt = tcsps_pkg::ST_ATTACHED;
						onMs_nxt = '0;
						silentMs_nxt = '0;
						fastLatch_nxt = 1'b0;
					end else begin
						hrMs_nxt = hrMs_r + tcsps_pkg::MS_ONE;
					end
				end
			end
			default: begin
				state_nxt = tcsps_pkg::ST_IDLE;
			end
		endcase
		if (detach) begin
			state_nxt = tcsps_pkg::ST_IDLE;
			debMs_nxt = '0;
			onMs_nxt = '0;
			silentMs_nxt = '0;
			hrMs_nxt = '0;
			fastLatch_nxt = 1'b0;
			indN_nxt = 1'b1;
			rail_nxt = 1'b0;
			hrTx_nxt = 1'b0;
		end
		if (!nrst) begin
			state_nxt = tcsps_pkg::ST_IDLE;
			debMs_nxt = '0;
			onMs_nxt = '0;
			silentMs_nxt = '0;
			hrMs_nxt = '0;
			orient_nxt = 1'b0;
			fastLatch_nxt = 1'b0;
			indN_nxt = 1'b1;
			rail_nxt = 1'b0;
			hrTx_nxt = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Power path outputs
	// ----------------------------------------------------------------
	// Gate turns off straight from synchronised pins, not via state,
	// so fast faults cost only three clocks.
	always_comb begin
		gate_nxt = 1'b0;
		vconn_nxt = 1'b0;
		if (state_nxt == tcsps_pkg::ST_ATTACHED ||
			state_nxt == tcsps_pkg::ST_HARDRST) begin
			gate_nxt = powerOk && !sFovp && !sOcp;
		end
		if (live && !detach) begin
			vconn_nxt = onMs_r >= tcsps_pkg::T_TURN_ON_MS;
		end
		// Pin levels are trusted only once both sync stages refilled
		warm_nxt = {warm_r[0], 1'b1};
		dsc_nxt = warm_r[1] && !gate_nxt && !sVbusLow && !sTemp;
		sel5_nxt = !(pdHighVoltReq && gate_nxt);
		pdEn_nxt = (state_nxt == tcsps_pkg::ST_ATTACHED) ||
			(state_nxt == tcsps_pkg::ST_HARDRST);
		if (!nrst) begin
			gate_nxt = 1'b0;
			vconn_nxt = 1'b0;
			dsc_nxt = 1'b0;
			sel5_nxt = 1'b1;
			pdEn_nxt = 1'b0;
			warm_nxt = '0;
		end
	end

	always_ff @(posedge mclk) begin
		state_r <= state_nxt;
		debMs_r <= debMs_nxt;
		onMs_r <= onMs_nxt;
		silentMs_r <= silentMs_nxt;
		hrMs_r <= hrMs_nxt;
		orient_r <= orient_nxt;
		fastLatch_r <= fastLatch_nxt;
		indN_r <= indN_nxt;
		rail_r <= rail_nxt;
		hrTx_r <= hrTx_nxt;
		gate_r <= gate_nxt;
		vconn_r <= vconn_nxt;
		dsc_r <= dsc_nxt;
		sel5_r <= sel5_nxt;
		pdEn_r <= pdEn_nxt;
		warm_r <= warm_nxt;
	end

	assign attach_indicator_n = indN_r;
	assign attach_rail_out = rail_r;
	assign ccOrient = orient_r;
	assign vconnEn = vconn_r;
	assign vconnToCc2 = vconn_r && !orient_r;
	assign vbus_nfet_gate = gate_r;
	assign sel5v = sel5_r;
	assign dischargeEn = dsc_r;
	assign pdEnable = pdEn_r;
	assign hardResetTx = hrTx_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	property p_ovr_off;
		!sOvrN |=> !vbus_nfet_gate;
	endproperty
	a_ovr_off: assert property (p_ovr_off) else $error("gate on in override");

	property p_fovp_off;
		sFovp |=> !vbus_nfet_gate ##1 !vbus_nfet_gate;
	endproperty
	a_fovp_off: assert property (p_fovp_off) else $error("gate on after OVP");

	property p_ocp_off;
		sOcp && state_r == tcsps_pkg::ST_ATTACHED |=> !vbus_nfet_gate;
	endproperty
	a_ocp_off: assert property (p_ocp_off) else $error("gate on after OCP");

	property p_temp_dsc;
		sTemp |=> !dischargeEn;
	endproperty
	a_temp_dsc: assert property (p_temp_dsc) else $error("discharge hot");

	property p_no_vbus_idle;
		(state_r == tcsps_pkg::ST_IDLE || state_r == tcsps_pkg::ST_DEBOUNCE)
			|-> !vbus_nfet_gate && !vconnEn;
	endproperty
	a_no_vbus_idle: assert property (p_no_vbus_idle) else $error("VBUS early");

	property p_rail_ind;
		attach_indicator_n == !attach_rail_out;
	endproperty
	a_rail_ind: assert property (p_rail_ind) else $error("rail mismatch");

	property p_debounce;
		$fell(attach_indicator_n) |->
			$past(debMs_r) == tcsps_pkg::T_DEBOUNCE_MS - tcsps_pkg::MS_ONE
			&& $past(msTick);
	endproperty
	a_debounce: assert property (p_debounce) else $error("debounce length");

	property p_vconn_time;
		$rose(vconnEn) |-> onMs_r <= tcsps_pkg::T_VCONN_MS;
	endproperty
	a_vconn_time: assert property (p_vconn_time) else $error("VCONN late");

	property p_hr_gate;
		state_r == tcsps_pkg::ST_HARDRST && msTick &&
			hrMs_r == tcsps_pkg::T_HR_GATE_MS - tcsps_pkg::MS_ONE && monRd
			|=> !vbus_nfet_gate && state_r == tcsps_pkg::ST_RECOVER;
	endproperty
	a_hr_gate: assert property (p_hr_gate) else $error("gate after HR");

	property p_detach;
		detach |=> state_r == tcsps_pkg::ST_IDLE && !vbus_nfet_gate
			&& !vconnEn && attach_indicator_n && onMs_r == '0;
	endproperty
	a_detach: assert property (p_detach) else $error("detach not handled");

	property p_hr_pulse;
		hardResetTx |-> $past(state_r) == tcsps_pkg::ST_ATTACHED &&
			state_r == tcsps_pkg::ST_HARDRST ##1 !hardResetTx;
	endproperty
	a_hr_pulse: assert property (p_hr_pulse) else $error("bad HR pulse");

	c_attach: cover property ($fell(attach_indicator_n));
	c_hr: cover property (hardResetTx);
	c_recover: cover property (state_r == tcsps_pkg::ST_RECOVER ##1
		state_r == tcsps_pkg::ST_ATTACHED);
	c_detach: cover property (detach);

endmodule

// ### sim/tcsps_bench.sv
// Self-checking bench for the Type-C source power sequencer
`timescale 1ns/1ns
module tcsps_bench;
	localparam int CPM = 10;
	localparam int LIMIT = 95000;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic gate_override_n = 1'b1;
	logic supply_monitor = 1'b1;
	logic fastOvp = 1'b0;
	logic current_sense_in = 1'b0;
	logic die_temp_limit = 1'b0;
	logic pdHighVoltReq = 1'b0;
	logic [1:0] plugCc = 2'h0;
	logic talk = 1'b0;
	logic [15:0] gapCyc = 16'h0064;
	logic [15:0] rnd = 16'hB962;
	logic cc1Rd, cc2Rd, vbusLow, pdMsgRx;
	logic attach_indicator_n, attach_rail_out, ccOrient, vconnEn, vconnToCc2;
	logic vbus_nfet_gate, sel5v, dischargeEn, pdEnable, hardResetTx;
	int errTotal = 0;
	int checkCount = 0;
	int cyc = 0;
	int n, m, e;
	int expMs[$];

	tcsps_top #(.CYC_PER_MS(CPM)) i_tcsps_top (.mclk(mclk), .nrst(nrst),
		.cc1Rd(cc1Rd), .cc2Rd(cc2Rd), .vbusLow(vbusLow),
		.gate_override_n(gate_override_n), .supply_monitor(supply_monitor),
		.fastOvp(fastOvp), .current_sense_in(current_sense_in),
		.die_temp_limit(die_temp_limit), .pdMsgRx(pdMsgRx),
		.pdHighVoltReq(pdHighVoltReq),
		.attach_indicator_n(attach_indicator_n),
		.attach_rail_out(attach_rail_out), .ccOrient(ccOrient),
		.vconnEn(vconnEn), .vconnToCc2(vconnToCc2),
		.vbus_nfet_gate(vbus_nfet_gate), .sel5v(sel5v),
		.dischargeEn(dischargeEn), .pdEnable(pdEnable),
		.hardResetTx(hardResetTx));

	tcsps_sink_model i_tcsps_sink_model (.mclk(mclk), .plugCc(plugCc),
		.talk(talk), .gapCyc(gapCyc), .vbus_nfet_gate(vbus_nfet_gate),
		.cc1Rd(cc1Rd), .cc2Rd(cc2Rd), .vbusLow(vbusLow), .pdMsgRx(pdMsgRx));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic outSel(input int s);
		case (s)
			0: return attach_indicator_n;
			1: return vbus_nfet_gate;
			2: return hardResetTx;
			3: return vconnEn;
			4: return dischargeEn;
			default: return sel5v;
		endcase
	endfunction

	task automatic results();
		$display("errors %0d checks %0d", errTotal, checkCount);
		if (errTotal == 0 && checkCount > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic got, input logic exp, input string what);
		checkCount++;
		if (got !== exp) begin
			errTotal++;
			$display("unexpected at %0t: %s is %b", $time, what, got);
		end
	endtask

	task automatic chkWin(input int got, input int lo, input int hi,
		input string what);
		checkCount++;
		if (got < lo || got > hi) begin
			errTotal++;
			$display("unexpected at %0t: %s took %0d", $time, what, got);
		end
	endtask

	// Counts edges until an output settles at a level; bounded
	task automatic waitSig(input int s, input logic v, output int cnt);
		cnt = 0;
		while (outSel(s) !== v && cnt < 60000) begin
			@(posedge mclk);
			#1;
			cnt++;
		end
	endtask

	task automatic attach(input logic [1:0] p, output int d);
		@(negedge mclk);
		plugCc = p;
		waitSig(0, 1'b0, d);
	endtask

	task automatic detach();
		@(negedge mclk);
		plugCc = 2'h0;
		waitSig(0, 1'b1, n);
		chkWin(n, 1, 4, "detach");
		chk(vbus_nfet_gate, 1'b0, "gate after detach");
		chk(vconnEn, 1'b0, "vconn after detach");
	endtask

	initial begin
		forever #10 mclk = ~mclk;
	end

	// A hang counts as a mismatch and closes the run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			errTotal++;
			$display("unexpected at %0t: run too long", $time);
			results();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(negedge mclk);
		chk(vbus_nfet_gate, 1'b0, "gate in reset");
		chk(sel5v, 1'b1, "5 V in reset");
		nrst = 1'b1;
		// Both pins pulled down is not a sink
		plugCc = 2'h3;
		repeat (190 * CPM) @(negedge mclk);
		chk(attach_indicator_n, 1'b1, "both pins");
		chk(vbus_nfet_gate, 1'b0, "gate unattached");
		plugCc = 2'h0;
		// Override low, then supply absent: one-shot hard reset
		for (int k = 0; k < 2; k++) begin
			@(negedge mclk);
			gate_override_n = (k != 0);
			supply_monitor = (k == 0);
			repeat (5) @(negedge mclk);
			attach(2'h1, n);
			chkWin(n, 184 * CPM, 186 * CPM + 5, "debounce");
			chk(attach_rail_out, 1'b1, "rail");
			chk(ccOrient, 1'b0, "orient cc1");
			chk(pdEnable, 1'b1, "pd engine");
			waitSig(2, 1'b1, n);
			chkWin(n, 599 * CPM, 600 * CPM + 3, "fault reset");
			chk(vbus_nfet_gate, 1'b0, "gate in fault");
			detach();
			@(negedge mclk);
			gate_override_n = 1'b1;
			supply_monitor = 1'b1;
		end
		// Silent sink: retry timing and recovery
		attach(2'h1, n);
		waitSig(3, 1'b1, n);
		chkWin(n, 0, 2 * CPM, "vconn on");
		chk(vconnToCc2, 1'b1, "vconn pin");
		waitSig(1, 1'b1, m);
		chkWin(n + m, 0, 2 * CPM, "gate on");
		chk(sel5v, 1'b1, "default 5 V");
		expMs = '{4800, 30, 765};
		waitSig(2, 1'b1, n);
		e = expMs.pop_front();
		chkWin(n, (e - 2) * CPM, e * CPM + 3, "silence");
		chk(vbus_nfet_gate, 1'b1, "gate kept");
		waitSig(1, 1'b0, n);
		e = expMs.pop_front();
		chkWin(n, (e - 1) * CPM, e * CPM + 3, "gate drop");
		waitSig(1, 1'b1, n);
		e = expMs.pop_front();
		chkWin(n, (e - 1) * CPM, (e + 2) * CPM + 3, "recover");
		@(negedge mclk);
		gate_override_n = 1'b0;
		waitSig(1, 1'b0, n);
		chkWin(n, 1, 4, "override off");
		waitSig(4, 1'b1, n);
		chkWin(n, 0, 4, "discharge on");
		@(negedge mclk);
		die_temp_limit = 1'b1;
		waitSig(4, 1'b0, n);
		chkWin(n, 1, 4, "hot discharge");
		@(negedge mclk);
		die_temp_limit = 1'b0;
		gate_override_n = 1'b1;
		detach();
		// Talking sink on CC2, then on CC1: high voltage, then fast faults
		for (int k = 0; k < 2; k++) begin
			rnd = lfsrNext(rnd);
			gapCyc = 16'h0020 + {7'h00, rnd[8:0]};
			talk = 1'b1;
			attach(k ? 2'h1 : 2'h2, n);
			chk(ccOrient, (k == 0), "orient");
			waitSig(1, 1'b1, n);
			@(negedge mclk);
			pdHighVoltReq = 1'b1;
			waitSig(5, 1'b0, n);
			chkWin(n, 0, 3, "high volt");
			@(negedge mclk);
			pdHighVoltReq = 1'b0;
			@(negedge mclk);
			fastOvp = (k == 0);
			current_sense_in = (k != 0);
			waitSig(1, 1'b0, n);
			chkWin(n, 1, 4, "fast shutdown");
			@(negedge mclk);
			fastOvp = 1'b0;
			current_sense_in = 1'b0;
			repeat (20 * CPM) @(negedge mclk);
			chk(vbus_nfet_gate, 1'b0, "fault latch");
			talk = 1'b0;
			detach();
		end
		results();
	end
endmodule

// ### sim/tcsps_sink_model.sv
// Behavioural sink attached across CC and VBUS
`timescale 1ns/1ns
module tcsps_sink_model (
	input wire logic mclk,            // System clock
	input wire logic [1:0] plugCc,    // Pull-down on CC1 bit 0, CC2 bit 1
	input wire logic talk,            // Sink sends PD messages
	input wire logic [15:0] gapCyc,   // Cycles between messages
	input wire logic vbus_nfet_gate,  // Source gate driver state
	output logic cc1Rd,               // CC1 pull-down seen
	output logic cc2Rd,               // CC2 pull-down seen
	output logic vbusLow,             // VBUS below safe level
	output logic pdMsgRx              // Pulse: message from sink
);
	int offCnt = 50;
	int gapCnt = 0;
	logic vbusLow_r = 1'b1;
	logic msg_r = 1'b0;

	assign vbusLow = vbusLow_r;
	assign pdMsgRx = msg_r;

	// A sink presents its pull-down on the pins it is plugged into
	assign cc1Rd = plugCc[0];
	assign cc2Rd = plugCc[1];

	// Bulk capacitance keeps VBUS up for 50 cycles after the gate drops,
	// which leaves a window where discharge is wanted
	always @(negedge mclk) begin
		if (vbus_nfet_gate) begin
			offCnt <= 0;
		end else if (offCnt < 50) begin
			offCnt <= offCnt + 1;
		end
		vbusLow_r <= !vbus_nfet_gate && offCnt >= 49;
	end

	// Messages only while powered; the gap sets a prompt or slow sink
	always @(negedge mclk) begin
		if (!talk || !vbus_nfet_gate) begin
			gapCnt <= 0;
			msg_r <= 1'b0;
		end else if (gapCnt >= int'(gapCyc)) begin
			gapCnt <= 0;
			msg_r <= 1'b1;
		end else begin
			gapCnt <= gapCnt + 1;
			msg_r <= 1'b0;
		end
	end
endmodule
